// ---- logic/sar_pkg.sv ----
package sar_pkg;

  // Result format
  localparam int unsigned SAR_BITS = 12;
  localparam logic [11:0] SAR_SIGN_MASK = 12'h800;
  localparam logic [11:0] SAR_ZERO = 12'h000;
  localparam logic [3:0] SAR_FULL_RES = 4'hC;

  // Local clock and link clock
  localparam int unsigned MCLK_PERIOD_NS = 100;
  localparam int unsigned LINK_DIV = 4;
  localparam int unsigned LINK_PERIOD_NS = MCLK_PERIOD_NS * LINK_DIV;
  localparam int unsigned LINK_FMIN_HZ = 10000;
  localparam int unsigned LINK_FMAX_HZ = 3200000;
  localparam int unsigned LINK_FREQ_HZ = 1000000000 / LINK_PERIOD_NS;

  // Power-on reset time
  localparam int unsigned POR_TIME_NS = 2500000;
  localparam int unsigned POR_MCLK = (POR_TIME_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam int unsigned POR_LINK_EDGES = POR_TIME_NS / LINK_PERIOD_NS;
  localparam int unsigned POR_MARGIN_MCLK = 16 * LINK_DIV;
  localparam int unsigned POR_HOST_WAIT = POR_MCLK + POR_MARGIN_MCLK;

  // Falling-edge numbers within a frame, counted from the select fall
  localparam logic [4:0] FALL_NULL = 5'h02;
  localparam logic [4:0] FALL_MSB = 5'h03;
  localparam logic [4:0] FALL_LSB = 5'h0E;
  localparam logic [4:0] FALL_REV_END = 5'h19;
  localparam logic [4:0] FALL_FLOAT = 5'h1A;
  localparam logic [4:0] FRAME_CLOCKS = 5'h10;

  // Host sequencer states
  typedef enum logic [1:0] {
    H_POR,
    H_IDLE,
    H_FRAME,
    H_GAP
  } sar_hstate_t;

endpackage

// ---- logic/sar_link_if.sv ----
`timescale 1ns/1ps
interface sar_link_if;
  logic conversion_clock;
  logic select_shutdown_n;
  logic dout;
  logic dout_oe;
  wire  dout_line;

  // Released line reads as the inverse, so a stray sample shows up
  assign dout_line = dout_oe ? dout : ~dout;

  modport dev (
    input  conversion_clock,
    input  select_shutdown_n,
    output dout,
    output dout_oe
  );

  modport host (
    output conversion_clock,
    output select_shutdown_n,
    input  dout_line
  );
endinterface

// ---- logic/sar_adc_device.sv ----
`timescale 1ns/1ps
module sar_adc_device
  import sar_pkg::*;
#(
  parameter int unsigned POR_EDGES = POR_LINK_EDGES
) (
  // Link
  sar_link_if.dev            link,
  // Power-on and analog stand-in
  input  wire logic          rst_i,
  input  wire logic [11:0]   ain_i,
  // Status
  output logic               dynamic_mode_o,
  output logic               por_done_o,
  output logic               primed_o
);

  function automatic logic [11:0] bit_mask(input logic [3:0] pos);
    bit_mask = 12'(12'h001 << pos);
  endfunction

  // Power-on reset counter
  logic [15:0] por_cnt_q;
  logic [15:0] por_cnt_d;
  logic        por_done_q;
  logic        por_last;

  // Frame state
  logic        frame_rst;
  logic        fresh_q;
  logic [4:0]  fall_q;
  logic [4:0]  fall_d;
  logic        step;
  logic [11:0] held_q;
  logic [11:0] held_ob;
  logic [11:0] sar_q;
  logic [11:0] sar_d;
  logic [11:0] result_tc;
  logic        dout_q;
  logic        oe_q;
  logic        primed_q;

  // Phase decode for the coming falling edge
  logic        at_null;
  logic        in_sar;
  logic        in_rev;
  logic        at_float;
  logic [3:0]  sar_pos;
  logic [3:0]  rev_pos;
  logic [11:0] trial;
  logic        keep;
  logic        sar_bit;
  logic        rev_bit;

  // Select high holds the frame logic cleared: abort and float
  assign frame_rst = rst_i | link.select_shutdown_n;

  // Static when select is high, dynamic when low, no clock needed
  assign dynamic_mode_o = ~link.select_shutdown_n;

  assign por_last  = (por_cnt_q == 16'(POR_EDGES - 1));
  assign por_cnt_d = 16'(por_cnt_q + 16'h0001);

  always_ff @(negedge link.conversion_clock or posedge rst_i) begin
    if (rst_i) begin
      por_cnt_q <= 16'h0000;
    end else if (!por_done_q) begin
      por_cnt_q <= por_cnt_d;
    end
  end

  always_ff @(negedge link.conversion_clock or posedge rst_i) begin
    if (rst_i) begin
      por_done_q <= 1'b0;
    end else if (por_last) begin
      por_done_q <= 1'b1;
    end
  end

  assign por_done_o = por_done_q;

  // Frame starts only on the first edge after a select fall, once reset is over
  assign step = ((fall_q != 5'h00) || (fresh_q && por_done_q))
                && (fall_q != FALL_FLOAT);
  assign fall_d = 5'(fall_q + 5'h01);

  assign at_null  = step && (fall_d == FALL_NULL);
  assign in_sar   = step && (fall_d >= FALL_MSB) && (fall_d <= FALL_LSB);
  assign in_rev   = step && (fall_d > FALL_LSB) && (fall_d <= FALL_REV_END);
  assign at_float = step && (fall_d == FALL_FLOAT);

  // Trial compare in offset binary
  assign held_ob = held_q ^ SAR_SIGN_MASK;
  assign sar_pos = 4'(FALL_LSB - fall_d);
  assign trial   = sar_q | bit_mask(sar_pos);
  assign keep    = (held_ob >= trial);
  assign sar_d   = keep ? trial : sar_q;

  // Offset binary to two's complement is a sign-bit flip
  assign result_tc = sar_q ^ SAR_SIGN_MASK;
  assign sar_bit   = keep ^ (sar_pos == 4'hB);
  assign rev_pos   = 4'(fall_d - FALL_LSB);
  assign rev_bit   = result_tc[rev_pos];

  always_ff @(negedge link.conversion_clock or posedge frame_rst) begin
    if (frame_rst) begin
      fresh_q <= 1'b1;
    end else begin
      fresh_q <= 1'b0;
    end
  end

  always_ff @(negedge link.conversion_clock or posedge frame_rst) begin
    if (frame_rst) begin
      fall_q <= 5'h00;
    end else if (step) begin
      fall_q <= fall_d;
    end
  end

  // Acquisition runs from the select fall to the second falling edge
  always_ff @(negedge link.conversion_clock or posedge frame_rst) begin
    if (frame_rst) begin
      held_q <= SAR_ZERO;
    end else if (at_null) begin
      held_q <= ain_i;
    end
  end

  always_ff @(negedge link.conversion_clock or posedge frame_rst) begin
    if (frame_rst) begin
      sar_q <= SAR_ZERO;
    end else if (in_sar) begin
      sar_q <= sar_d;
    end
  end

  // Output bit changes on falling edges; reset or select high clears it
  always_ff @(negedge link.conversion_clock or posedge frame_rst) begin
    if (frame_rst) begin
      dout_q <= 1'b0;
    end else if (at_null) begin
      dout_q <= 1'b0;
    end else if (in_sar) begin
      dout_q <= sar_bit;
    end else if (in_rev) begin
      dout_q <= rev_bit;
    end
  end

  always_ff @(negedge link.conversion_clock or posedge frame_rst) begin
    if (frame_rst) begin
      oe_q <= 1'b0;
    end else if (at_null) begin
      oe_q <= 1'b1;
    end else if (at_float) begin
      oe_q <= 1'b0;
    end
  end

  // Set once the track-and-hold has seen a complete conversion
  always_ff @(negedge link.conversion_clock or posedge rst_i) begin
    if (rst_i) begin
      primed_q <= 1'b0;
    end else if (step && (fall_d == FALL_LSB)) begin
      primed_q <= 1'b1;
    end
  end

  assign primed_o = primed_q;

  assign link.dout    = dout_q;
  assign link.dout_oe = oe_q & ~link.select_shutdown_n;

endmodule

// ---- logic/sar_adc_host.sv ----
`timescale 1ns/1ps
module sar_adc_host
  import sar_pkg::*;
#(
  parameter int unsigned POR_WAIT = POR_HOST_WAIT
) (
  // Clock and reset
  input  wire logic          mclk_i,
  input  wire logic          rst_i,
  // Link
  sar_link_if.host           link,
  // Request
  input  wire logic          start_i,
  input  wire logic [3:0]    res_bits_i,
  output logic               ready_o,
  output logic               busy_o,
  // Result
  output logic [11:0]        result_o,
  output logic [3:0]         result_bits_o,
  output logic               result_valid_o
);

  function automatic logic [3:0] eff_bits(input logic [3:0] req);
    eff_bits = ((req == 4'h0) || (req > SAR_FULL_RES)) ? SAR_FULL_RES : req;
  endfunction

  sar_hstate_t state_q;
  sar_hstate_t state_d;
  logic [1:0]  div_q;
  logic [1:0]  div_d;
  logic        clk_q;
  logic        fall_ev;
  logic        low_ev;
  logic        sel_n_q;
  logic        sel_n_d;
  logic        sync1_q;
  logic        sync2_q;
  logic [15:0] por_cnt_q;
  logic        por_end;
  logic        dummy_q;
  logic        pend_q;
  logic [3:0]  nbits_q;
  logic [4:0]  evt_q;
  logic [4:0]  evt_d;
  logic [4:0]  end_evt;
  logic        capture;
  logic        frame_end;
  logic        begin_frame;
  logic        accept;
  logic [11:0] sh_q;
  logic [11:0] sh_d;
  logic [11:0] res_q;
  logic [3:0]  rbits_q;
  logic        valid_q;

  // Link clock divided from mclk, 400 ns with the defaults
  assign div_d   = 2'(div_q + 2'h1);
  assign fall_ev = (div_q == 2'h3);
  // Select drops mid low phase, clear of both clock edges
  assign low_ev  = (div_q == 2'h0);

  assign por_end     = (por_cnt_q == 16'(POR_WAIT - 1));
  assign accept      = start_i && ready_o;
  assign begin_frame = (state_q == H_IDLE) && low_ev && (pend_q || dummy_q);
  assign evt_d       = 5'(evt_q + 5'h01);
  // Sixteen clocks for full width, fewer for a short cycle
  assign end_evt     = (nbits_q == SAR_FULL_RES) ? FRAME_CLOCKS
                       : 5'(FALL_MSB + {1'b0, nbits_q});
  // Bit from falling edge k-1 was sampled at rise k: drop the null bit
  assign capture     = (state_q == H_FRAME) && fall_ev
                       && (evt_d > FALL_MSB) && (evt_d <= 5'(FALL_MSB + {1'b0, nbits_q}));
  assign frame_end   = (state_q == H_FRAME) && fall_ev && (evt_d == end_evt);
  assign sh_d        = {sh_q[10:0], sync2_q};

  always_comb begin
    state_d = state_q;
    sel_n_d = sel_n_q;
    case (state_q)
      H_POR: begin
        if (por_end) begin
          state_d = H_IDLE;
        end
      end
      H_IDLE: begin
        if (begin_frame) begin
          state_d = H_FRAME;
          sel_n_d = 1'b0;
        end
      end
      H_FRAME: begin
        if (frame_end) begin
          state_d = H_GAP;
          sel_n_d = 1'b1;
        end
      end
      H_GAP: begin
        if (fall_ev) begin
          state_d = H_IDLE;
        end
      end
      default: begin
        state_d = H_POR;
        sel_n_d = 1'b1;
      end
    endcase
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      div_q   <= 2'h0;
      clk_q   <= 1'b0;
      state_q <= H_POR;
      sel_n_q <= 1'b1;
    end else begin
      div_q   <= div_d;
      clk_q   <= div_d[1];
      state_q <= state_d;
      sel_n_q <= sel_n_d;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end else begin
      sync1_q <= link.dout_line;
      sync2_q <= sync1_q;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      por_cnt_q <= 16'h0000;
    end else if ((state_q == H_POR) && !por_end) begin
      por_cnt_q <= 16'(por_cnt_q + 16'h0001);
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      dummy_q <= 1'b1;
      pend_q  <= 1'b0;
      nbits_q <= SAR_FULL_RES;
    end else if (begin_frame) begin
      pend_q  <= 1'b0;
      nbits_q <= dummy_q ? SAR_FULL_RES : nbits_q;
    end else if (frame_end) begin
      dummy_q <= 1'b0;
    end else if (accept) begin
      pend_q  <= 1'b1;
      nbits_q <= eff_bits(res_bits_i);
    end
  end

  // Every frame keeps the full acquisition time, short or not
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      evt_q <= 5'h00;
      sh_q  <= SAR_ZERO;
    end else if (begin_frame) begin
      evt_q <= 5'h00;
      sh_q  <= SAR_ZERO;
    end else if ((state_q == H_FRAME) && fall_ev) begin
      evt_q <= evt_d;
      sh_q  <= capture ? sh_d : sh_q;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      res_q   <= SAR_ZERO;
      rbits_q <= 4'h0;
      valid_q <= 1'b0;
    end else begin
      valid_q <= frame_end && !dummy_q;
      if (frame_end && !dummy_q) begin
        res_q   <= 12'((capture ? sh_d : sh_q) << (4'(SAR_BITS) - nbits_q));
        rbits_q <= nbits_q;
      end
    end
  end

  assign ready_o        = (state_q == H_IDLE) && !pend_q && !dummy_q;
  assign busy_o         = (state_q != H_IDLE) || pend_q || dummy_q;
  assign result_o       = res_q;
  assign result_bits_o  = rbits_q;
  assign result_valid_o = valid_q;

  assign link.conversion_clock  = clk_q;
  assign link.select_shutdown_n = sel_n_q;

endmodule

// ---- dv/sar_link_monitor.sv ----
`timescale 1ns/1ps
module sar_link_monitor (
  // Link
  input  wire logic conversion_clock,
  input  wire logic select_shutdown_n,
  input  wire logic dout,
  input  wire logic dout_oe,
  // Reset
  input  wire logic rst_i
);
  logic [4:0]  cnt_q;
  logic [21:0] sh_q;
  wire  [5:0]  idx = {cnt_q, 1'b0} - 6'h1D;

  // Falling edges since select fall
  always_ff @(negedge conversion_clock or posedge select_shutdown_n) begin
    if (select_shutdown_n) cnt_q <= 5'h00;
    else if (cnt_q != 5'h1F) cnt_q <= cnt_q + 5'h01;
  end
  always_ff @(posedge conversion_clock) sh_q <= {sh_q[20:0], dout};

  default clocking @(posedge conversion_clock); endclocking
  default disable iff (rst_i);

  abort_float_a: assert property (select_shutdown_n |-> !dout_oe)
    else $error("output driven while deselected");
  oe_rise_a: assert property ($rose(dout_oe) |-> cnt_q == 5'h02)
    else $error("output enabled at wrong edge");
  null_bit_a: assert property (cnt_q == 5'h02 && dout_oe |-> !dout)
    else $error("null bit not zero");
  oe_hold_a: assert property (dout_oe && cnt_q inside {[5'h02:5'h18]}
    |=> dout_oe || select_shutdown_n) else $error("output dropped mid frame");
  reverse_a: assert property (cnt_q inside {[5'h0F:5'h19]} && dout_oe
    |-> dout == sh_q[idx]) else $error("reverse bit mismatch");
  float_end_a: assert property (cnt_q >= 5'h1A |-> !dout_oe)
    else $error("output not floated after resend");
  sel_setup_a: assert property ($fell(select_shutdown_n) |-> cnt_q == 5'h00)
    else $error("select fell while clock high");
  frame_len_a: assert property (@(posedge select_shutdown_n)
    cnt_q inside {[5'h03:5'h10]}) else $error("frame length out of range");
endmodule

// ---- dv/sar_adc_serial_readout_tb_top.sv ----
`timescale 1ns/1ps
module sar_adc_serial_readout_tb_top;
  import sar_pkg::*;
  logic        mclk_i     = 1'b0;
  logic        rst_i      = 1'b0;
  logic        start_i    = 1'b0;
  logic [3:0]  res_bits_i = 4'hC;
  logic [11:0] ain_i      = 12'h000;
  logic [11:0] ain2       = 12'h000;
  logic        ready_o;
  logic        busy_o;
  logic        result_valid_o;
  logic        dyn2_o;
  logic        por2_o;
  logic        primed2_o;
  logic [11:0] result_o;
  logic [3:0]  result_bits_o;
  int          errors       = 0;
  int          total_checks = 0;

  sar_link_if link ();
  sar_link_if link2 ();
  always #50 mclk_i = ~mclk_i;

  sar_adc_host #(.POR_WAIT(200)) sar_adc_host_i (.mclk_i(mclk_i), .rst_i(rst_i),
    .link(link.host), .start_i(start_i), .res_bits_i(res_bits_i), .ready_o(ready_o),
    .busy_o(busy_o), .result_o(result_o), .result_bits_o(result_bits_o),
    .result_valid_o(result_valid_o));
  sar_adc_device #(.POR_EDGES(40)) sar_adc_device_i (.link(link.dev), .rst_i(rst_i),
    .ain_i(ain_i), .dynamic_mode_o(), .por_done_o(), .primed_o());
  // Second device, link driven by the bench
  sar_adc_device #(.POR_EDGES(40)) sar_adc_device_b_i (.link(link2.dev), .rst_i(rst_i),
    .ain_i(ain2), .dynamic_mode_o(dyn2_o), .por_done_o(por2_o), .primed_o(primed2_o));
  sar_link_monitor sar_link_monitor_i (.conversion_clock(link.conversion_clock),
    .select_shutdown_n(link.select_shutdown_n), .dout(link.dout),
    .dout_oe(link.dout_oe), .rst_i(rst_i));

  task automatic results;
    if (errors == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wait_for(input bit v);
    int k;
    for (k = 0; k < 400 && (v ? result_valid_o : ready_o) !== 1'b1; k++) @(negedge mclk_i);
    if (k == 400) begin
      errors++;
      results();
    end
  endtask

  task automatic conversion_phase(input logic [11:0] code, input logic [3:0] n);
    wait_for(1'b0);
    ain_i = code;
    res_bits_i = n;
    start_i = 1'b1;
    @(negedge mclk_i);
    start_i = 1'b0;
    wait_for(1'b1);
  endtask

  task automatic t_power_up;
    ain_i = 12'h5A5;
    repeat (10) @(negedge mclk_i);
    chk({11'h0, ready_o}, 12'h000);
    wait_for(1'b0);
    chk({11'h0, busy_o}, 12'h000);
    chk(result_o, 12'h000);
    chk({8'h0, result_bits_o}, 12'h000);
  endtask

  task automatic t_codes;
    logic [11:0] c [6] = '{12'h800, 12'h801, 12'h000, 12'h7FE, 12'h7FF, 12'hA5C};
    foreach (c[i]) begin
      conversion_phase(c[i], 4'hC);
      chk(result_o, c[i]);
      chk({8'h0, result_bits_o}, {8'h0, SAR_FULL_RES});
    end
  endtask

  task automatic t_short;
    logic [3:0] n [3] = '{4'h1, 4'h4, 4'hB};
    logic [11:0] m;
    foreach (n[i]) begin
      m = 12'hFFF << (12 - n[i]);
      conversion_phase(12'hB6D, n[i]);
      chk(result_o, 12'hB6D & m);
      chk({8'h0, result_bits_o}, {8'h0, n[i]});
    end
    conversion_phase(12'h3C9, 4'hC);
    chk(result_o, 12'h3C9);
  endtask

  task automatic l2_clk(input int n);
    repeat (n) begin
      #40 link2.conversion_clock = 1'b1;
      #40 link2.conversion_clock = 1'b0;
    end
  endtask

  task automatic l2_frame(input logic [11:0] code, input bit check);
    int f;
    logic e;
    ain2 = code;
    #20 link2.select_shutdown_n = 1'b0;
    for (int k = 1; k <= 28; k++) begin
      #40 link2.conversion_clock = 1'b1;
      f = k - 1;
      e = (f == 2) ? 1'b0 : code[(f <= 14) ? 14 - f : f - 14];
      if (check && f >= 2 && f <= 25)
        chk({10'h0, link2.dout_oe, link2.dout_line}, {10'h0, 1'b1, e});
      else if (check)
        chk({11'h0, link2.dout_oe}, 12'h000);
      #40 link2.conversion_clock = 1'b0;
    end
    #20 link2.select_shutdown_n = 1'b1;
  endtask

  task automatic l2_abort;
    #20 link2.select_shutdown_n = 1'b0;
    l2_clk(6);
    #20 chk({10'h0, link2.dout_oe, dyn2_o}, 12'h003);
    link2.select_shutdown_n = 1'b1;
    #1 chk({10'h0, link2.dout_oe, dyn2_o}, 12'h000);
  endtask

  task automatic t_dev_por;
    chk({10'h0, por2_o, primed2_o}, 12'h000);
    l2_clk(39);
    #10 chk({10'h0, por2_o, primed2_o}, 12'h000);
    l2_clk(6);
    #10 chk({10'h0, por2_o, primed2_o}, 12'h002);
    l2_frame(12'h9C3, 1'b0);
    #10 chk({10'h0, por2_o, primed2_o}, 12'h003);
  endtask

  initial begin
    rst_i <= 1'b1;
    link2.conversion_clock = 1'b0;
    link2.select_shutdown_n = 1'b1;
    repeat (10) @(negedge mclk_i);
    rst_i <= 1'b0;
    t_power_up();
    t_codes();
    t_short();
    t_dev_por();
    l2_frame(12'h9C3, 1'b1);
    l2_abort();
    l2_frame(12'h36A, 1'b1);
    results();
  end
endmodule
